// ==== core/frs_top.sv ====
// instruction decode, embedded-operation sequencing and status reads of the flash
`timescale 1ns/1ps
`include "frs_map.svh"

module frs_top
    import frs_pkg::*;
#(
    parameter int unsigned PROG_CYC = `FRS_PROG_CYC,
    parameter int unsigned ERASE_CYC = `FRS_ERASE_CYC,
    parameter int unsigned PROT_CYC = `FRS_PROT_CYC,
    parameter int unsigned WIN_CYC = `FRS_WIN_CYC,
    parameter int unsigned GAP_CYC = `FRS_GAP_CYC
)
(
    input wire logic CORE_CLK,
    input wire logic RESETN,
    input wire logic [`FRS_AW-1:0] HOST_ADDR,
    input wire logic [`FRS_DW-1:0] HOST_DIN,
    input wire logic [15:0] PRIMARY_SECTOR_SELECTS,
    input wire logic [3:0] SECONDARY_SECTOR_SELECTS,
    input wire logic STORE_STROBE_LOW,
    input wire logic READ_STROBE_LOW,
    input wire logic BIG_ENDIAN_HOST,
    input wire logic [`FRS_NSEC-1:0] SECTOR_PROTECT,
    input wire logic [`FRS_DW-1:0] ARRAY_RDATA,
    input wire logic ARRAY_FAIL,
    output logic [`FRS_DW-1:0] HOST_DOUT,
    output logic HOST_DOUT_OE_N,
    output logic READY_BUSY_PIN,
    output frs_array_cmd_t ARRAY_CMD
);

    // ----------------------------------------------------------------------
    // strobes, selects and timers
    // ----------------------------------------------------------------------
    frs_state_t s_reg;
    frs_state_t s_next;
    logic wr_fall;
    logic rd_fall;
    logic any_sel;
    logic sel_bank;
    logic wr_ok;
    logic rd_ok;
    logic prot_hit;
    logic [`FRS_NSEC-1:0] sel_vec;
    logic [7:0] cmd;
    logic op_load;
    logic [`FRS_TMR_W-1:0] op_val;
    logic op_done;
    logic win_load;
    logic win_done;
    logic gap_done;
    logic status_mode;

    frs_edge u_wr_edge (
        .clk(CORE_CLK),
        .rst_n(RESETN),
        .strobe_n(STORE_STROBE_LOW),
        .fall(wr_fall)
    );

    frs_edge u_rd_edge (
        .clk(CORE_CLK),
        .rst_n(RESETN),
        .strobe_n(READ_STROBE_LOW),
        .fall(rd_fall)
    );

    frs_timer u_op_tmr (
        .clk(CORE_CLK),
        .rst_n(RESETN),
        .load(op_load),
        .load_val(op_val),
        .busy(),
        .done(op_done)
    );

    frs_timer u_win_tmr (
        .clk(CORE_CLK),
        .rst_n(RESETN),
        .load(win_load),
        .load_val(`FRS_TMR_W'(WIN_CYC)),
        .busy(),
        .done(win_done)
    );

    // restarted by every write, so it measures the gap between instruction bytes
    frs_timer u_gap_tmr (
        .clk(CORE_CLK),
        .rst_n(RESETN),
        .load(wr_ok),
        .load_val(`FRS_TMR_W'(GAP_CYC)),
        .busy(),
        .done(gap_done)
    );

    assign sel_vec = {SECONDARY_SECTOR_SELECTS, PRIMARY_SECTOR_SELECTS};
    assign any_sel = |sel_vec;
    // primary wins if both banks are selected at once
    assign sel_bank = ~(|PRIMARY_SECTOR_SELECTS);
    assign wr_ok = wr_fall & any_sel;
    assign rd_ok = rd_fall & any_sel;
    assign prot_hit = |(sel_vec & SECTOR_PROTECT);
    assign cmd = HOST_DIN[7:0];
    assign status_mode = (s_reg.mode == FRS_WIN) || (s_reg.mode == FRS_BUSY_PROG)
        || (s_reg.mode == FRS_BUSY_ERA) || (s_reg.mode == FRS_PROT)
        || (s_reg.mode == FRS_FAIL);

    // ----------------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------------
    always_comb
    begin
        logic start_erase;
        logic [`FRS_NSEC-1:0] unprot;
        logic [7:0] st;
        logic poll;
        start_erase = 1'b0;
        unprot = '0;
        st = '0;
        poll = 1'b0;
        s_next = s_reg;
        s_next.arr.prog = 1'b0;
        s_next.arr.erase = 1'b0;
        s_next.dout_oe_n = READ_STROBE_LOW | ~any_sel;
        op_load = 1'b0;
        op_val = '0;
        win_load = 1'b0;

        if (wr_ok)
        begin
            case (s_reg.mode)
                FRS_READ:
                begin
                    s_next.bank = sel_bank;
                    if (HOST_ADDR == `FRS_UNLK_ADDR1 && cmd == `FRS_CMD_UNLK1)
                        s_next.mode = FRS_UNLK1;
                end
                FRS_UNLK1:
                begin
                    if (HOST_ADDR == `FRS_UNLK_ADDR2 && cmd == `FRS_CMD_UNLK2)
                        s_next.mode = FRS_UNLK2;
                    else
                        s_next.mode = FRS_READ;
                end
                FRS_UNLK2:
                begin
                    s_next.mode = FRS_READ;
                    if (HOST_ADDR == `FRS_UNLK_ADDR1)
                    begin
                        if (cmd == `FRS_CMD_ID)
                            s_next.mode = FRS_ID;
                        else if (cmd == `FRS_CMD_PROG)
                            s_next.mode = FRS_PGM;
                        else if (cmd == `FRS_CMD_ERASE)
                            s_next.mode = FRS_ERA1;
                    end
                end
                FRS_PGM:
                begin
                    if (prot_hit)
                        s_next.mode = FRS_READ;
                    else
                    begin
                        s_next.mode = FRS_BUSY_PROG;
                        s_next.op_prog = 1'b1;
                        s_next.pd = HOST_DIN;
                        s_next.arr.addr = HOST_ADDR;
                        s_next.arr.data = HOST_DIN;
                        s_next.fail = |(HOST_DIN & ~ARRAY_RDATA);
                        s_next.toggle = 1'b0;
                        op_load = 1'b1;
                        op_val = `FRS_TMR_W'(PROG_CYC);
                    end
                end
                FRS_ERA1:
                    s_next.mode = (HOST_ADDR == `FRS_UNLK_ADDR1 && cmd == `FRS_CMD_UNLK1)
                        ? FRS_ERA2 : FRS_READ;
                FRS_ERA2:
                    s_next.mode = (HOST_ADDR == `FRS_UNLK_ADDR2 && cmd == `FRS_CMD_UNLK2)
                        ? FRS_ERA3 : FRS_READ;
                FRS_ERA3:
                begin
                    s_next.mode = FRS_READ;
                    if (HOST_ADDR == `FRS_UNLK_ADDR1 && cmd == `FRS_CMD_BULK)
                    begin
                        s_next.sectors = s_reg.bank ? `FRS_SEC_MASK : `FRS_PRI_MASK;
                        start_erase = 1'b1;
                    end
                    else if (cmd == `FRS_CMD_SECTOR)
                    begin
                        s_next.mode = FRS_WIN;
                        s_next.sectors = sel_vec;
                        s_next.win_flag = 1'b0;
                        // a stale program target would otherwise steer the polling bit
                        s_next.op_prog = 1'b0;
                        s_next.toggle = 1'b0;
                        win_load = 1'b1;
                    end
                end
                FRS_WIN:
                begin
                    if (cmd == `FRS_CMD_SECTOR)
                    begin
                        s_next.sectors = s_reg.sectors | sel_vec;
                        s_next.win_flag = 1'b1;
                        win_load = 1'b1;
                    end
                    else
                        s_next.mode = FRS_READ;
                end
                FRS_ID:
                    s_next.mode = FRS_READ;
                FRS_FAIL:
                begin
                    if (cmd == `FRS_CMD_RESET)
                    begin
                        s_next.mode = FRS_READ;
                        s_next.fail = 1'b0;
                    end
                end
                default:
                    s_next.mode = s_reg.mode;
            endcase
        end

        // a quiet bus between instruction bytes abandons the sequence
        if (gap_done && (s_reg.mode == FRS_UNLK1 || s_reg.mode == FRS_UNLK2
            || s_reg.mode == FRS_PGM || s_reg.mode == FRS_ERA1
            || s_reg.mode == FRS_ERA2 || s_reg.mode == FRS_ERA3))
            s_next.mode = FRS_READ;

        if (win_done && s_reg.mode == FRS_WIN && !win_load)
            start_erase = 1'b1;

        if (start_erase)
        begin
            unprot = s_next.sectors & ~SECTOR_PROTECT;
            s_next.op_prog = 1'b0;
            s_next.toggle = 1'b0;
            s_next.win_flag = 1'b1;
            op_load = 1'b1;
            if (unprot == '0)
            begin
                s_next.mode = FRS_PROT;
                op_val = `FRS_TMR_W'(PROT_CYC);
            end
            else
            begin
                s_next.mode = FRS_BUSY_ERA;
                s_next.arr.erase = 1'b1;
                s_next.arr.sectors = unprot;
                op_val = `FRS_TMR_W'(ERASE_CYC);
            end
        end

        // internal failure wins over any clear in the same cycle
        if (ARRAY_FAIL && (s_reg.mode == FRS_BUSY_PROG || s_reg.mode == FRS_BUSY_ERA))
            s_next.fail = 1'b1;

        if (op_done)
        begin
            case (s_reg.mode)
                FRS_BUSY_PROG:
                begin
                    if (s_next.fail)
                        s_next.mode = FRS_FAIL;
                    else
                    begin
                        s_next.mode = FRS_READ;
                        s_next.arr.prog = 1'b1;
                    end
                end
                FRS_BUSY_ERA:
                    s_next.mode = s_next.fail ? FRS_FAIL : FRS_READ;
                FRS_PROT:
                    s_next.mode = FRS_READ;
                default:
                    s_next.mode = s_next.mode;
            endcase
        end

        if (rd_ok)
        begin
            if (status_mode && sel_bank == s_reg.bank)
            begin
                if (s_reg.op_prog)
                    poll = ~(BIG_ENDIAN_HOST ? s_reg.pd[15] : s_reg.pd[7]);
                else
                    poll = 1'b0;
                if (s_reg.mode != FRS_PROT)
                    s_next.toggle = ~s_reg.toggle;
                st[`FRS_POLL_BIT] = poll;
                st[`FRS_TOG_BIT] = s_next.toggle;
                st[`FRS_FAIL_BIT] = s_reg.fail;
                st[`FRS_WIN_BIT] = s_reg.win_flag;
                s_next.dout = BIG_ENDIAN_HOST ? {st, 8'h00} : {8'h00, st};
            end
            else if (s_reg.mode == FRS_ID && HOST_ADDR == `FRS_ID_ADDR && !sel_bank)
                s_next.dout = {8'h00, `FRS_ID_CODE};
            else if (s_reg.mode == FRS_ID && HOST_ADDR == `FRS_PROT_ADDR)
                s_next.dout = {15'h0000, prot_hit};
            else
                s_next.dout = ARRAY_RDATA;
        end

        s_next.rdy = !(s_next.mode == FRS_WIN || s_next.mode == FRS_BUSY_PROG
            || s_next.mode == FRS_BUSY_ERA || s_next.mode == FRS_PROT);
    end

    // every path out of reset lands in plain array reads
    always_ff @(posedge CORE_CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            s_reg <= '0;
            s_reg.mode <= FRS_READ;
            s_reg.dout_oe_n <= 1'b1;
            s_reg.rdy <= 1'b1;
        end
        else
            s_reg <= s_next;
    end

    assign HOST_DOUT = s_reg.dout;
    assign HOST_DOUT_OE_N = s_reg.dout_oe_n;
    assign READY_BUSY_PIN = s_reg.rdy;
    assign ARRAY_CMD = s_reg.arr;

    // ----------------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------------
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!RESETN);

    chk_id_answer: assert property (
        rd_ok && s_reg.mode == FRS_ID && HOST_ADDR == `FRS_ID_ADDR && !sel_bank
        |=> HOST_DOUT == {8'h00, `FRS_ID_CODE})
        else $error("identifier read gave wrong value");

    chk_prot_answer: assert property (
        rd_ok && s_reg.mode == FRS_ID && HOST_ADDR == `FRS_PROT_ADDR
        |=> HOST_DOUT == {15'h0000, $past(prot_hit)})
        else $error("protection read gave wrong value");

    chk_prog_poll_inv: assert property (
        rd_ok && s_reg.mode == FRS_BUSY_PROG && sel_bank == s_reg.bank && !BIG_ENDIAN_HOST
        |=> HOST_DOUT[`FRS_POLL_BIT] == ~s_reg.pd[7])
        else $error("program polling bit not inverted");

    chk_erase_poll_zero: assert property (
        rd_ok && s_reg.mode == FRS_BUSY_ERA && sel_bank == s_reg.bank && BIG_ENDIAN_HOST
        |=> HOST_DOUT[8+`FRS_POLL_BIT] == 1'b0 && HOST_DOUT[7:0] == 8'h00)
        else $error("erase polling bit not zero in upper byte");

    chk_toggle_flip: assert property (
        rd_ok && sel_bank == s_reg.bank && (s_reg.mode == FRS_BUSY_PROG
        || s_reg.mode == FRS_BUSY_ERA) |=> s_reg.toggle != $past(s_reg.toggle))
        else $error("toggle flag did not flip on busy read");

    chk_prot_prog_drop: assert property (
        wr_ok && s_reg.mode == FRS_PGM && prot_hit
        |=> s_reg.mode == FRS_READ ##1 !ARRAY_CMD.prog)
        else $error("protected program was not discarded");

    chk_prot_erase_win: assert property (
        s_reg.mode != FRS_PROT ##1 s_reg.mode == FRS_PROT
        |-> (s_reg.mode == FRS_PROT && !ARRAY_CMD.erase)[*8])
        else $error("protected erase left its window early");

    chk_fail_clear: assert property (
        wr_ok && s_reg.mode == FRS_FAIL && cmd == `FRS_CMD_RESET
        |=> !s_reg.fail && s_reg.mode == FRS_READ)
        else $error("reset instruction did not clear error flag");

    chk_zero_to_one: assert property (
        wr_ok && s_reg.mode == FRS_PGM && !prot_hit && |(HOST_DIN & ~ARRAY_RDATA)
        |=> s_reg.fail && s_reg.mode == FRS_BUSY_PROG)
        else $error("illegal program did not raise error");

    chk_win_flag: assert property (
        wr_ok && s_reg.mode == FRS_ERA3 && cmd == `FRS_CMD_SECTOR
        |=> !s_reg.win_flag && s_reg.mode == FRS_WIN)
        else $error("erase window flag not cleared at window start");

    chk_ready_pin: assert property (
        s_reg.mode == FRS_BUSY_PROG || s_reg.mode == FRS_BUSY_ERA |-> !READY_BUSY_PIN)
        else $error("ready pin high while busy");

    chk_gap_abort: assert property (
        gap_done && !wr_ok && (s_reg.mode == FRS_UNLK1 || s_reg.mode == FRS_UNLK2)
        |=> s_reg.mode == FRS_READ)
        else $error("instruction gap did not abort");

endmodule : frs_top

// ==== core/frs_map.svh ====
// constants of the flash read and status block: offsets, codes, fields and timing
//
// Summary of operation
// - power-up places flash logic in read mode
// - after any reset both banks read array
// - primary answers identifier read; secondary does not
// - protection read returns 01h protected, 00h not
// - status: poll b7, toggle b6, error b5, window b3
// - big-endian 16-bit host gets status in upper byte
// - status at even address, readable without limit
// - program polling bit reads inverted, then true data
// - status valid after fourth/sixth write; host polls target
// - erase polling bit reads 0, then stored value
// - program into protected sector is discarded
// - all-protected erase: status zero ~100 us, no erase; here window b3 reads 1
// - toggle flips on every read of busy bank
// - toggling stops at end; host sees equal reads
// - error flag 0 normally, 1 on any failure
// - error on 0-to-1 program or internal timeout
// - host issues reset instruction; error flag then clears
// - completion visible by polling, toggle, ready/busy pin
// - bad byte or long gap returns to read mode
`ifndef FRS_MAP_SVH
`define FRS_MAP_SVH

// --------------------------------------------------------------------------
// widths and instruction coding
// --------------------------------------------------------------------------
`define FRS_AW 12
`define FRS_DW 16
`define FRS_NSEC 20
`define FRS_TMR_W 13
`define FRS_UNLK_ADDR1 12'h555
`define FRS_UNLK_ADDR2 12'hAAA
`define FRS_ID_ADDR 12'h001
`define FRS_PROT_ADDR 12'h002
`define FRS_CMD_UNLK1 8'hAA
`define FRS_CMD_UNLK2 8'h55
`define FRS_CMD_ID 8'h90
`define FRS_CMD_PROG 8'hA0
`define FRS_CMD_ERASE 8'h80
`define FRS_CMD_BULK 8'h10
`define FRS_CMD_SECTOR 8'h30
`define FRS_CMD_RESET 8'hF0
// arbitrary identifier value
`define FRS_ID_CODE 8'h5A
`define FRS_PRI_MASK 20'h0_FFFF
`define FRS_SEC_MASK 20'hF_0000

// --------------------------------------------------------------------------
// status byte fields
// --------------------------------------------------------------------------
`define FRS_POLL_BIT 7
`define FRS_TOG_BIT 6
`define FRS_FAIL_BIT 5
`define FRS_WIN_BIT 3

// --------------------------------------------------------------------------
// timing at a 10 MHz core clock
// --------------------------------------------------------------------------
`define FRS_CLK_MHZ 10
`define FRS_WIN_US 100
`define FRS_WIN_MARGIN_PCT 20
`define FRS_PROT_US 100
`define FRS_GAP_US 80
`define FRS_PROG_US 10
`define FRS_ERASE_US 300
`define FRS_WIN_CYC (`FRS_WIN_US * (100 + `FRS_WIN_MARGIN_PCT) * `FRS_CLK_MHZ / 100)
`define FRS_PROT_CYC (`FRS_PROT_US * `FRS_CLK_MHZ)
`define FRS_GAP_CYC (`FRS_GAP_US * `FRS_CLK_MHZ)
`define FRS_PROG_CYC (`FRS_PROG_US * `FRS_CLK_MHZ)
`define FRS_ERASE_CYC (`FRS_ERASE_US * `FRS_CLK_MHZ)

`endif

// ==== core/frs_pkg.sv ====
// types shared by the flash read and status block
`include "frs_map.svh"

package frs_pkg;

    typedef enum logic [3:0] {
        FRS_READ, FRS_UNLK1, FRS_UNLK2, FRS_ID, FRS_PGM, FRS_ERA1, FRS_ERA2,
        FRS_ERA3, FRS_WIN, FRS_BUSY_PROG, FRS_BUSY_ERA, FRS_PROT, FRS_FAIL
    } frs_mode_t;

    typedef struct packed {
        logic prog;
        logic erase;
        logic [`FRS_AW-1:0] addr;
        logic [`FRS_DW-1:0] data;
        logic [`FRS_NSEC-1:0] sectors;
    } frs_array_cmd_t;

    typedef struct packed {
        frs_mode_t mode;
        logic bank;
        logic op_prog;
        logic fail;
        logic win_flag;
        logic toggle;
        logic [`FRS_NSEC-1:0] sectors;
        logic [`FRS_DW-1:0] pd;
        logic [`FRS_DW-1:0] dout;
        logic dout_oe_n;
        logic rdy;
        frs_array_cmd_t arr;
    } frs_state_t;

    typedef struct packed {
        logic [`FRS_TMR_W-1:0] cnt;
        logic done;
    } frs_tmr_state_t;

    typedef struct packed {
        logic prev;
    } frs_edge_state_t;

endpackage : frs_pkg

// ==== core/frs_edge.sv ====
// falling-edge detector for an active-low strobe
`timescale 1ns/1ps

module frs_edge
    import frs_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic strobe_n,
    output logic fall
);

    frs_edge_state_t s_reg;
    frs_edge_state_t s_next;

    always_comb
    begin
        s_next.prev = strobe_n;
    end

    // idle level is high, so a strobe held high through power-up gives no edge
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            s_reg <= '{prev: 1'b1};
        else
            s_reg <= s_next;
    end

    assign fall = s_reg.prev & ~strobe_n;

endmodule : frs_edge

// ==== core/frs_timer.sv ====
// loadable down-counter with a one-cycle done pulse
`timescale 1ns/1ps

module frs_timer
    import frs_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic load,
    input wire logic [`FRS_TMR_W-1:0] load_val,
    output logic busy,
    output logic done
);

    frs_tmr_state_t s_reg;
    frs_tmr_state_t s_next;

    always_comb
    begin
        s_next = s_reg;
        s_next.done = 1'b0;
        if (load)
            s_next.cnt = load_val;
        else if (s_reg.cnt != '0)
        begin
            s_next.cnt = s_reg.cnt - `FRS_TMR_W'(1);
            s_next.done = (s_reg.cnt == `FRS_TMR_W'(1));
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            s_reg <= '0;
        else
            s_reg <= s_next;
    end

    assign busy = (s_reg.cnt != '0);
    assign done = s_reg.done;

endmodule : frs_timer

// ==== tb/frs_array_model.sv ====
// flash array model behind the block's array port
`timescale 1ns/1ps
`include "frs_map.svh"

module frs_array_model
    import frs_pkg::*;
(
    input wire logic clk,
    input wire logic [`FRS_AW-1:0] addr,
    input frs_array_cmd_t cmd,
    output logic [`FRS_DW-1:0] rdata
);
    logic [`FRS_DW-1:0] mem [16];

    // low words start erased, high words start programmed to zero
    initial
    begin
        for (int i = 0; i < 16; i++)
            mem[i] = (i < 8) ? 16'hFFFF : 16'h0000;
    end

    assign rdata = mem[addr[3:0]];

    // programming can only clear bits, so a bad program leaves a trace
    always @(posedge clk)
    begin
        if (cmd.prog)
            mem[cmd.addr[3:0]] <= mem[cmd.addr[3:0]] & cmd.data;
        if (cmd.erase)
            for (int i = 0; i < 16; i++)
                mem[i] <= 16'hFFFF;
    end
endmodule : frs_array_model

// ==== tb/test_frs_top.sv ====
// self-checking bench of the flash read and status block
`timescale 1ns/1ps
`include "frs_map.svh"

module test_frs_top;
    import frs_pkg::*;
    logic clk = 0;
    logic rst_n = 0;
    logic [`FRS_AW-1:0] addr = '0;
    logic [`FRS_DW-1:0] din = '0;
    logic [19:0] sel = '0;
    logic wr_n = 1;
    logic rd_n = 1;
    logic big = 0;
    logic [19:0] prot = 20'h0_0002;
    logic afail = 0;
    logic [`FRS_DW-1:0] rdata, dout, d, d0;
    logic oe_n, rdy;
    frs_array_cmd_t cmd;
    int mismatches = 0;
    int samples_checked = 0;

    frs_top #(.PROG_CYC(20), .ERASE_CYC(60), .PROT_CYC(20), .WIN_CYC(12), .GAP_CYC(40))
    frs_top_i (.CORE_CLK(clk), .RESETN(rst_n), .HOST_ADDR(addr), .HOST_DIN(din),
        .PRIMARY_SECTOR_SELECTS(sel[15:0]), .SECONDARY_SECTOR_SELECTS(sel[19:16]),
        .STORE_STROBE_LOW(wr_n), .READ_STROBE_LOW(rd_n), .BIG_ENDIAN_HOST(big),
        .SECTOR_PROTECT(prot), .ARRAY_RDATA(rdata), .ARRAY_FAIL(afail),
        .HOST_DOUT(dout), .HOST_DOUT_OE_N(oe_n), .READY_BUSY_PIN(rdy), .ARRAY_CMD(cmd));

    frs_array_model frs_array_model_i (.clk(clk), .addr(addr), .cmd(cmd), .rdata(rdata));

    initial
    begin
        forever #50 clk = ~clk;
    end

    // ------------------------------------------------------------------
    // access and compare tasks
    // ------------------------------------------------------------------
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : conclude

    task automatic check_word(input logic [15:0] got, input logic [15:0] exp, input string m);
        samples_checked++;
        if (got !== exp)
        begin
            mismatches++;
            $display("CHECK FAILED at %0t: %s got %h want %h", $time, m, got, exp);
        end
    endtask : check_word

    task automatic check_bit(input logic got, input logic exp, input string m);
        check_word({15'h0000, got}, {15'h0000, exp}, m);
    endtask : check_bit

    task automatic wr(input logic [11:0] a, input logic [15:0] v);
        @(negedge clk);
        addr = a;
        din = v;
        wr_n = 0;
        @(negedge clk);
        wr_n = 1;
    endtask : wr

    // answer lands one edge after the strobe is taken
    task automatic rd(input logic [11:0] a);
        @(negedge clk);
        addr = a;
        rd_n = 0;
        @(negedge clk);
        @(negedge clk);
        d = dout;
        check_bit(oe_n, 1'b0, "drive enable");
        rd_n = 1;
    endtask : rd

    task automatic cmd3(input logic [7:0] c);
        wr(`FRS_UNLK_ADDR1, {8'h00, `FRS_CMD_UNLK1});
        wr(`FRS_UNLK_ADDR2, {8'h00, `FRS_CMD_UNLK2});
        wr(`FRS_UNLK_ADDR1, {8'h00, c});
    endtask : cmd3

    task automatic wait_ready();
        int n;
        n = 0;
        while (rdy !== 1'b1 && n < 500)
        begin
            @(negedge clk);
            n++;
        end
        if (n == 500)
        begin
            mismatches++;
            $display("CHECK FAILED at %0t: ready never returned", $time);
            conclude();
        end
    endtask : wait_ready

    // ------------------------------------------------------------------
    // test sequence
    // ------------------------------------------------------------------
    initial
    begin
        repeat (4) @(negedge clk);
        rst_n = 1;
        check_bit(rdy, 1'b1, "ready after reset");
        check_bit(oe_n, 1'b1, "drive off after reset");
        sel = 20'h0_0001;
        rd(12'h002);
        check_word(d, 16'hFFFF, "array after reset");
        sel = 20'h0_0002;
        cmd3(`FRS_CMD_ID);
        rd(`FRS_ID_ADDR);
        check_word(d, {8'h00, `FRS_ID_CODE}, "identifier");
        rd(`FRS_PROT_ADDR);
        check_word(d, 16'h0001, "protected sector");
        sel = 20'h0_0001;
        rd(`FRS_PROT_ADDR);
        check_word(d, 16'h0000, "open sector");
        wr(12'h000, {8'h00, `FRS_CMD_RESET});
        sel = 20'h1_0000;
        cmd3(`FRS_CMD_ID);
        rd(`FRS_ID_ADDR);
        check_word(d, 16'hFFFF, "secondary has no identifier");
        wr(12'h000, {8'h00, `FRS_CMD_RESET});
        cmd3(8'h77);
        rd(12'h002);
        check_word(d, 16'hFFFF, "bad byte back to read");
        $display("test read modes done");
        sel = 20'h0_0002;
        cmd3(`FRS_CMD_PROG);
        wr(12'h002, 16'h0000);
        check_bit(rdy, 1'b1, "protected program ignored");
        rd(12'h002);
        check_word(d, 16'hFFFF, "protected word kept");
        sel = 20'h0_0001;
        cmd3(`FRS_CMD_PROG);
        wr(12'h002, 16'h1234);
        rd(12'h002);
        d0 = d;
        check_word(d0 & 16'hFFB7, 16'h0080, "program status");
        check_bit(rdy, 1'b0, "busy pin");
        rd(12'h002);
        check_bit(d[6], ~d0[6], "toggle");
        wait_ready();
        rd(12'h002);
        check_word(d, 16'h1234, "programmed word");
        rd(12'h002);
        check_word(d, 16'h1234, "toggling stopped");
        cmd3(`FRS_CMD_PROG);
        wr(12'h009, 16'hFFFF);
        repeat (30) @(negedge clk);
        rd(12'h009);
        check_bit(d[5], 1'b1, "error on zero to one");
        wr(12'h000, {8'h00, `FRS_CMD_RESET});
        rd(12'h009);
        check_word(d, 16'h0000, "reset clears error");
        $display("test program done");
        sel = 20'h0_0004;
        cmd3(`FRS_CMD_ERASE);
        cmd3(`FRS_CMD_SECTOR);
        rd(12'h002);
        check_word(d & 16'hFFBF, 16'h0000, "erase window status");
        check_bit(rdy, 1'b0, "busy in window");
        repeat (15) @(negedge clk);
        big = 1;
        rd(12'h002);
        check_word(d & 16'hBFFF, 16'h0800, "upper byte status");
        big = 0;
        wait_ready();
        rd(12'h002);
        check_word(d, 16'hFFFF, "erased word");
        sel = 20'h0_0002;
        cmd3(`FRS_CMD_ERASE);
        cmd3(`FRS_CMD_SECTOR);
        repeat (14) @(negedge clk);
        rd(12'h002);
        check_word(d & 16'h00C0, 16'h0000, "protected erase status");
        wait_ready();
        sel = 20'h1_0000;
        cmd3(`FRS_CMD_ERASE);
        cmd3(`FRS_CMD_BULK);
        repeat (20) @(negedge clk);
        afail = 1;
        @(negedge clk);
        afail = 0;
        wait_ready();
        rd(12'h002);
        check_word(d & 16'h00BF, 16'h0028, "bulk erase failure status");
        wr(12'h000, {8'h00, `FRS_CMD_RESET});
        rd(12'h002);
        check_word(d, 16'hFFFF, "array after failure reset");
        $display("test erase done");
        conclude();
    end

    initial
    begin
        repeat (20000) @(posedge clk);
        mismatches++;
        $display("CHECK FAILED at %0t: run limit reached", $time);
        conclude();
    end
endmodule : test_frs_top
